// [logic/gdc_ctrl.sv]
// Purpose: controller that drives the isolated gate driver command and reset/enable pins
// Assumes: inputs synchronous to clk_in; fault and ready pins open-drain with pull-ups
// Notes: the fault clear is an active-low pulse on reset/enable after the mute time
`timescale 1ns/10ps
`default_nettype none
module gdc_ctrl
  import gdc_pkg::*;
#(
  parameter int FAULT_MUTE_NS = FAULT_MUTE_NS_DEF,
  parameter int MUTE_CYC = (FAULT_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic pwm_own_in,
  input wire logic pwm_opp_in,
  input wire logic use_interlock_in,
  input wire logic auto_reset_in,
  input wire logic invert_mode_in,
  input wire logic fault_alert_n_in,
  input wire logic ready_in,
  output logic cmd_pos_out,
  output logic cmd_neg_out,
  output logic rst_en_out,
  output logic fault_seen_out,
  output logic supply_ok_out,
  output logic busy_out
);
  gdc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  gdc_cmd_t cmd, next_cmd;
  logic [CNT_W-1:0] hold_pos, next_hold_pos;
  logic [CNT_W-1:0] hold_neg, next_hold_neg;
  logic rst_en, next_rst_en;
  logic fault_seen, next_fault_seen;
  logic supply_ok, next_supply_ok;
  logic busy, next_busy;
  gdc_cmd_t want;
  logic fault_low;

  // wide enough pulses only; a change is held for the filter length
  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
    dec_sat = (v == '0) ? v : v - 16'h0001;
  endfunction : dec_sat

  always_comb begin
    fault_low = ~fault_alert_n_in;
    want.pos = pwm_own_in;
    want.neg = use_interlock_in ? pwm_opp_in : 1'b0;
    if (want.pos && want.neg) begin
      want.pos = 1'b0;
    end
  end

  always_comb begin
    next_cmd = cmd;
    next_hold_pos = dec_sat(hold_pos);
    next_hold_neg = dec_sat(hold_neg);
    // a change is only allowed after the last one has lived long enough
    if (want.pos != cmd.pos && hold_pos == '0) begin
      next_cmd.pos = want.pos;
      next_hold_pos = CNT_W'(DEGLITCH_CYC - 1);
    end
    if (want.neg != cmd.neg && hold_neg == '0) begin
      next_cmd.neg = want.neg;
      next_hold_neg = CNT_W'(DEGLITCH_CYC - 1);
    end
    // one pin may not rise while the other is still pinned high by its window
    if (next_cmd.pos && next_cmd.neg) begin
      if (cmd.pos) begin
        next_cmd.neg = cmd.neg;
        next_hold_neg = dec_sat(hold_neg);
      end else begin
        next_cmd.pos = cmd.pos;
        next_hold_pos = dec_sat(hold_pos);
      end
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = dec_sat(cnt);
    next_rst_en = rst_en;
    next_fault_seen = fault_seen;
    next_busy = 1'b0;
    // released ready pin reads high through its pull-up: supply good
    next_supply_ok = ready_in;
    unique case (state)
      GDC_OFF: begin
        next_rst_en = 1'b0;
        if (enable_in && cnt == '0) begin
          next_state = GDC_RUN;
          next_rst_en = 1'b1;
          next_cnt = CNT_W'(DEGLITCH_CYC);
        end
      end
      GDC_RUN: begin
        // auto reset follows pwm; pwm pulses wider than filter are assumed
        if (auto_reset_in) begin
          next_rst_en = invert_mode_in ? ~pwm_own_in : pwm_own_in;
        end else begin
          next_rst_en = 1'b1;
        end
        if (!enable_in) begin
          next_state = GDC_OFF;
          next_rst_en = 1'b0;
          next_cnt = CNT_W'(DEGLITCH_CYC);
        end else if (fault_low && !auto_reset_in) begin
          next_state = GDC_MUTE;
          next_fault_seen = 1'b1;
          next_cnt = CNT_W'(MUTE_CYC);
        end else if (fault_low) begin
          next_fault_seen = 1'b1;
        end
      end
      GDC_MUTE: begin
        next_busy = 1'b1;
        if (cnt == '0) begin
          next_state = GDC_CLEAR;
          next_rst_en = 1'b0;
          next_cnt = CNT_W'(RESET_PULSE_CYC);
        end
      end
      GDC_CLEAR: begin
        next_busy = 1'b1;
        next_rst_en = 1'b0;
        if (cnt == '0) begin
          next_state = GDC_RUN;
          next_rst_en = enable_in;
          next_fault_seen = 1'b0;
          next_cnt = CNT_W'(DEGLITCH_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= GDC_OFF;
      cnt <= '0;
      cmd <= '0;
      hold_pos <= '0;
      hold_neg <= '0;
      rst_en <= 1'b0;
      fault_seen <= 1'b0;
      supply_ok <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      hold_pos <= next_hold_pos;
      hold_neg <= next_hold_neg;
      rst_en <= next_rst_en;
      fault_seen <= next_fault_seen;
      supply_ok <= next_supply_ok;
      busy <= next_busy;
    end
  end

  assign cmd_pos_out = cmd.pos;
  assign cmd_neg_out = cmd.neg;
  assign rst_en_out = rst_en;
  assign fault_seen_out = fault_seen;
  assign supply_ok_out = supply_ok;
  assign busy_out = busy;

  property p_no_overlap;
    @(posedge clk_in) disable iff (reset_in) !(cmd.pos && cmd.neg);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pos and neg both high");

  property p_neg_tied;
    @(posedge clk_in) disable iff (reset_in)
      (!use_interlock_in && hold_neg == '0) |=> !cmd.neg || use_interlock_in;
  endproperty
  a_neg_tied: assert property (p_neg_tied) else $error("neg not tied low");

  property p_pos_width;
    @(posedge clk_in) disable iff (reset_in)
      $rose(cmd.pos) |-> cmd.pos [*2];
  endproperty
  a_pos_width: assert property (p_pos_width) else $error("short pos pulse");

  property p_neg_width;
    @(posedge clk_in) disable iff (reset_in)
      $fell(cmd.neg) |-> !cmd.neg [*2];
  endproperty
  a_neg_width: assert property (p_neg_width) else $error("short neg gap");

  property p_mute_hold;
    @(posedge clk_in) disable iff (reset_in)
      (state == GDC_MUTE && cnt != '0) |-> rst_en ##1 (state == GDC_MUTE && rst_en);
  endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("reset during mute");

  property p_clear_low;
    @(posedge clk_in) disable iff (reset_in)
      (state == GDC_MUTE && cnt == '0) |=> !rst_en_out && state == GDC_CLEAR;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("no clear pulse");

  property p_disable;
    @(posedge clk_in) disable iff (reset_in)
      (state == GDC_RUN && !enable_in) |=> !rst_en;
  endproperty
  a_disable: assert property (p_disable) else $error("enable not dropped");

  property p_auto;
    @(posedge clk_in) disable iff (reset_in)
      (state == GDC_RUN && enable_in && auto_reset_in && !fault_low && !invert_mode_in)
        |=> rst_en == $past(pwm_own_in);
  endproperty
  a_auto: assert property (p_auto) else $error("auto reset not following pwm");
endmodule : gdc_ctrl
`default_nettype wire

// [logic/gdc_pkg.sv]
// Purpose: shared constants and types for the gate driver input controller
// Assumes: 40 MHz clock
// Notes: times in ns, counts derived from the clock rate
package gdc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEGLITCH_NS = 40;
  // a pulse must outlast the driver filter, so round up and add one cycle of margin
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int FAULT_MUTE_NS_DEF = 10000;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic pos;
    logic neg;
  } gdc_cmd_t;

  typedef enum logic [1:0] {
    GDC_RUN,
    GDC_MUTE,
    GDC_CLEAR,
    GDC_OFF
  } gdc_state_t;
endpackage : gdc_pkg

// [tb/gdc_ctrl_test.sv]
// Purpose: self-checking bench for gdc_ctrl
// Assumes: mute time shortened to 100 ns
// Notes: open-drain levels resolved here with pull-ups
`timescale 1ns/10ps
`default_nettype none
module gdc_ctrl_test;
  import gdc_pkg::*;
  localparam int MUTE_NS = 100;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, own = 1'b0, opp = 1'b0, il = 1'b0;
  logic ar = 1'b0, inv = 1'b0, oc = 1'b0, sup = 1'b1, prev = 1'b0;
  wire logic pos, neg, rst_en, seen, ok, busy, fault_oe, rdy_oe, gate;
  wire logic fault_n = !fault_oe;
  wire logic rdy = !rdy_oe;
  int seed = 24303, miscompares = 0, samples_checked = 0, run = 8, n, il_low = 0;
  realtime t0;
  always #12.5 clk = !clk;
  gdc_ctrl #(.FAULT_MUTE_NS(MUTE_NS)) i_gdc_ctrl (.clk_in(clk), .reset_in(rst),
    .enable_in(en), .pwm_own_in(own), .pwm_opp_in(opp), .use_interlock_in(il),
    .auto_reset_in(ar), .invert_mode_in(inv), .fault_alert_n_in(fault_n),
    .ready_in(rdy), .cmd_pos_out(pos), .cmd_neg_out(neg), .rst_en_out(rst_en),
    .fault_seen_out(seen), .supply_ok_out(ok), .busy_out(busy));
  gdc_drv_model i_gdc_drv_model (.pos_in(pos), .neg_in(neg), .rst_en_in(rst_en),
    .oc_in(oc), .supply_in(sup), .fault_oe_out(fault_oe), .rdy_oe_out(rdy_oe),
    .gate_pullup_out(gate), .gate_pulldown_out());
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  task automatic wait_en(input logic v);
    n = 0;
    while (rst_en !== v && n < 100) begin
      step(1);
      n++;
    end
  endtask : wait_en
  task automatic results();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // short command pulses would be swallowed by the driver filter
  // sampled on the falling edge, where the registered outputs have settled
  always @(negedge clk) if (!rst) begin
    check("interlock", 1'b0, pos & neg);
    il_low = il ? 0 : il_low + 1;
    // a pending neg change may still sit out its hold window after il drops
    if (il_low > DEGLITCH_CYC) check("neg tied", 1'b0, neg);
    if (pos !== prev) begin
      check("pos width", 1'b1, run >= DEGLITCH_CYC);
      run = 1;
    end else run++;
    prev = pos;
  end
  initial begin
    step(8);
    check("rst_en reset", 1'b0, rst_en);
    rst = 1'b0;
    en = 1'b1;
    wait_en(1'b1);
    check("enable", 1'b1, rst_en);
    $display("enable done");
    for (int c = 0; c < 4; c++) begin
      {own, opp} = 2'(c);
      il = 1'b1;
      step(8);
      check("pos", c == 2, pos);
      check("neg", c[0], neg);
      check("gate", c == 2, gate);
    end
    for (int i = 0; i < 300; i++) begin
      {own, opp, il} = 3'($random(seed));
      step(1 + $unsigned($random(seed)) % 8);
    end
    $display("pwm done");
    {own, opp} = 2'b10;
    step(8);
    oc = 1'b1;
    t0 = $realtime;
    step(1);
    oc = 1'b0;
    step(3);
    check("seen", 1'b1, seen);
    check("busy", 1'b1, busy);
    check("gate held off", 1'b0, gate);
    wait_en(1'b0);
    // rst_en fell at the edge 2 ns before this sample
    check("mute wait", 1'b1, $realtime - t0 - 2 >= MUTE_NS);
    wait_en(1'b1);
    check("clear pulse", 1'b1, n == RESET_PULSE_CYC + 1);
    step(2);
    check("seen cleared", 1'b0, seen);
    check("busy end", 1'b0, busy);
    $display("fault done");
    ar = 1'b1;
    for (int c = 0; c < 4; c++) begin
      {inv, own} = 2'(c);
      step(8);
      check("auto", own ^ inv, rst_en);
    end
    ar = 1'b0;
    inv = 1'b0;
    en = 1'b0;
    step(4);
    check("disable", 1'b0, rst_en);
    for (int i = 0; i < 4; i++) begin
      sup = 1'($random(seed));
      step(2);
      check("supply", sup, ok);
    end
    $display("status done");
    results();
  end
  initial begin
    #(20000 * CLK_PERIOD_NS);
    miscompares++;
    results();
  end
endmodule : gdc_ctrl_test
`default_nettype wire

// [tb/gdc_drv_model.sv]
// Purpose: behavioural model of the isolated gate driver
// Assumes: inertial 40 ns delay stands in for the deglitch filter
// Notes: open-drain pins appear as pull-down enables
`timescale 1ns/10ps
`default_nettype none
module gdc_drv_model (
  input wire logic pos_in,
  input wire logic neg_in,
  input wire logic rst_en_in,
  input wire logic oc_in,
  input wire logic supply_in,
  output logic fault_oe_out,
  output logic rdy_oe_out,
  output logic gate_pullup_out,
  output logic gate_pulldown_out
);
  wire logic f_pos, f_neg, f_en;
  logic lat = 1'b0;
  assign #40 f_pos = pos_in;
  assign #40 f_neg = neg_in;
  // floating pin reads as low
  assign #40 f_en = (rst_en_in === 1'b1);
  always @* if (!f_en) lat = 1'b0; else if (oc_in) lat = 1'b1;
  assign fault_oe_out = lat;
  assign rdy_oe_out = !supply_in;
  assign gate_pullup_out = f_pos & !f_neg & f_en & !lat;
  assign gate_pulldown_out = !gate_pullup_out;
endmodule : gdc_drv_model
`default_nettype wire
